// *** motor_cfg_pkg.sv ***
package motor_cfg_pkg;

  // ****************************************************************
  // Register indices; byte address is four times the index
  // ****************************************************************
  localparam logic [7:0] IDX_SAMPLE_COUNT = 8'h74;
  localparam logic [7:0] IDX_SAMPLE_PERIOD = 8'h75;
  localparam logic [7:0] IDX_SCOPE_CONTROL = 8'h76;
  localparam logic [7:0] IDX_BUFFER_CAPACITY = 8'h77;
  localparam logic [7:0] IDX_INDEX_DISTANCE = 8'h78;
  localparam logic [7:0] IDX_RESERVED_A = 8'h79;
  localparam logic [7:0] IDX_HOMING_OPTIONS = 8'h7A;
  localparam logic [7:0] IDX_FAULT_RESPONSE = 8'h7B;
  localparam logic [7:0] IDX_OPTION_FLAGS = 8'h7C;
  localparam logic [7:0] IDX_IO_SETUP = 8'h7D;
  localparam logic [7:0] IDX_TABLE_MODE = 8'h7E;
  localparam logic [7:0] IDX_TABLE_LENGTH = 8'h7F;
  localparam logic [7:0] IDX_RESERVED_B = 8'h80;
  localparam logic [7:0] IDX_NEG_LIMIT = 8'h81;
  localparam logic [7:0] IDX_POS_LIMIT = 8'h82;
  localparam logic [7:0] IDX_SERVO_ON = 8'h83;
  localparam logic [7:0] IDX_HOME_SELECT = 8'h84;
  localparam logic [7:0] IDX_RESERVED_C = 8'h85;
  localparam logic [7:0] IDX_RESERVED_D = 8'h86;

  // ****************************************************************
  // Reset values and constants
  // ****************************************************************
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] RST_SAMPLE_PERIOD = 32'h0000_0001;
  localparam logic [31:0] BUFFER_CAPACITY_VALUE = 32'h0000_0000;
  localparam logic [10:0] INDEX_DISTANCE_MAX = 11'h63F;
  localparam int SAMPLE_PERIOD_MS = 1;
  localparam int CLK_MHZ = 100;
  localparam int CYCLES_PER_MS = CLK_MHZ * 1000;

  // ****************************************************************
  // Field positions and masks
  // ****************************************************************
  localparam logic [31:0] HOMING_MASK = 32'h0000_0017;
  localparam logic [31:0] OPTION_MASK = 32'h0003_3FEF;
  localparam logic [31:0] IO_SETUP_MASK = 32'h0000_FFFF;
  localparam logic [31:0] TABLE_MODE_MASK = 32'h0000_0003;
  localparam logic [31:0] IO_MASK = 32'h0000_00FF;
  localparam int HB_INDEX = 0;
  localparam int HB_REVERSE = 1;
  localparam int HB_OPPOSITE = 2;
  localparam int HB_IGNORE_SWITCH = 4;
  localparam int OB_INVERT = 0;
  localparam int OB_NO_AUTOSTART = 1;
  localparam int OB_ENC_TYPE_LO = 2;
  localparam int OB_RESYNC = 5;
  localparam int OB_PHYS_POS = 6;
  localparam int OB_ENC_A_OUT = 7;
  localparam int OB_ENC_B_OUT = 8;
  localparam int OB_ENC_I_OUT = 9;
  localparam int OB_COPY_ENC = 10;
  localparam int OB_MULTITURN = 11;
  localparam int OB_RETAIN_EXT = 12;
  localparam int OB_RETAIN_ABS = 13;
  localparam int OB_EXT_DIR = 16;
  localparam int OB_NO_LIMIT_ERR = 17;

  typedef enum logic [1:0] {
    ENC_OFF = 2'h0,
    ENC_QUAD = 2'h1,
    ENC_PULSE_DIR = 2'h2,
    ENC_UNDEFINED = 2'h3
  } encoder_kind_type;

  typedef enum logic [1:0] {
    TABLE_LINEAR = 2'h0,
    TABLE_POSITIVE = 2'h1,
    TABLE_NEGATIVE = 2'h2,
    TABLE_SHORTEST = 2'h3
  } table_mode_type;

  // ****************************************************************
  // Bundles
  // ****************************************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

  typedef struct packed {
    logic index_search;
    logic reverse_on_limit;
    logic opposite_side;
    logic index_only;
  } homing_type;

  typedef struct packed {
    logic invert_dir;
    logic no_autostart;
    encoder_kind_type enc_kind;
    logic enc_enable;
    logic resync_after_passive;
    logic phys_position;
    logic [2:0] enc_out_en;
    logic copy_enc_to_actual_position;
    logic multiturn;
    logic retain_external_count;
    logic retain_absolute_count;
    logic external_count_direction;
    logic no_limit_error;
  } options_type;

  typedef struct packed {
    logic [7:0] active_level;
    logic [7:0] output_en;
    table_mode_type table_mode;
    logic table_active;
    logic [31:0] table_modulo;
    logic [7:0] neg_limit_sel;
    logic [7:0] pos_limit_sel;
    logic [7:0] servo_on_sel;
    logic [7:0] home_sel;
  } io_cfg_type;

  typedef struct packed {
    logic [31:0] sample_count;
    logic [31:0] sample_period_ms;
    logic [31:0] scope_control;
  } scope_cfg_type;

endpackage : motor_cfg_pkg

// *** motor_config_register_bank.sv ***
// The strobed register port was left to the implementer.
`timescale 1ns/1ns

// Operation
// - Sample count register, writable, resets to zero.
// - Sample period register in milliseconds, writable, resets to one.
// - Scope control register, writable, resets to zero, drives sampling.
// - Read-only buffer capacity register; feature planned, reads a fixed value.
// - Read-only sensor-to-index distance 0-1599, captured after index homing.
// - Homing bit 0 searches index; bit 4 ignores home switch.
// - Homing bit 1 reverses at limit; bit 2 seeks sensor opposite side.
// - Option bit 0 inverts direction; bit 1 blocks program autostart.
// - Option bits 2-3: encoder off, quadrature, or pulse/direction.
// - Option bits 7, 8, 9 enable encoder A, B, index outputs.
// - Option bit 17 suppresses error on travel or position limit.
// - Bit 5 resyncs after passive, bit 10 copies encoder, bit 11 multiturn.
// - Bits 12, 13 retain external/absolute counts; bit 16 external direction.
// - I/O setup bits 0-7 active levels, bits 8-15 output enables.
// - Rotary mode: linear, positive only, negative only, shortest route.
// - Rotary length used as modulo only when mode is nonzero.
// - Separate masks select negative and positive limit inputs.
// - Each home mask bit selects one of I/O lines 1-8.
module motor_config_register_bank (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Homing engine report, same clock domain
  input wire logic homing_done,
  input wire logic homing_used_index,
  input wire logic [10:0] homing_index_distance,
  // Configuration to the motion, encoder and I/O logic
  output motor_cfg_pkg::scope_cfg_type scope_cfg,
  output motor_cfg_pkg::homing_type homing_cfg,
  output motor_cfg_pkg::options_type option_cfg,
  output motor_cfg_pkg::io_cfg_type io_cfg
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [31:0] sample_count;
    logic [31:0] sample_period;
    logic [31:0] scope_control;
    logic [10:0] index_distance;
    logic [31:0] homing;
    logic [31:0] options;
    logic [31:0] io_setup;
    logic [31:0] table_mode;
    logic [31:0] table_length;
    logic [31:0] neg_limit;
    logic [31:0] pos_limit;
    logic [31:0] servo_on;
    logic [31:0] home_sel;
    logic [31:0] rdata;
    motor_cfg_pkg::scope_cfg_type scope;
    motor_cfg_pkg::homing_type hom;
    motor_cfg_pkg::options_type opt;
    motor_cfg_pkg::io_cfg_type io;
  } state_type;

  state_type state_reg;
  state_type state_next;
  motor_cfg_pkg::bus_req_type req;

  assign req.addr = reg_addr;
  assign req.wdata = reg_wdata;
  assign req.wr = reg_wr;
  assign req.rd = reg_rd;

  // Undefined encoder codes fall back to off so a bad write never enables counting
  function automatic motor_cfg_pkg::encoder_kind_type decode_encoder(input logic [1:0] code);
    case (code)
      2'h1: decode_encoder = motor_cfg_pkg::ENC_QUAD;
      2'h2: decode_encoder = motor_cfg_pkg::ENC_PULSE_DIR;
      default: decode_encoder = motor_cfg_pkg::ENC_OFF;
    endcase
  endfunction : decode_encoder

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    state_next = state_reg;
    // Writes
    if (req.wr)
    begin
      case (req.addr)
        motor_cfg_pkg::IDX_SAMPLE_COUNT: state_next.sample_count = req.wdata;
        motor_cfg_pkg::IDX_SAMPLE_PERIOD: state_next.sample_period = req.wdata;
        motor_cfg_pkg::IDX_SCOPE_CONTROL: state_next.scope_control = req.wdata;
        motor_cfg_pkg::IDX_HOMING_OPTIONS: state_next.homing = req.wdata & motor_cfg_pkg::HOMING_MASK;
        motor_cfg_pkg::IDX_OPTION_FLAGS: state_next.options = req.wdata & motor_cfg_pkg::OPTION_MASK;
        motor_cfg_pkg::IDX_IO_SETUP: state_next.io_setup = req.wdata & motor_cfg_pkg::IO_SETUP_MASK;
        motor_cfg_pkg::IDX_TABLE_MODE: state_next.table_mode = req.wdata & motor_cfg_pkg::TABLE_MODE_MASK;
        motor_cfg_pkg::IDX_TABLE_LENGTH: state_next.table_length = req.wdata;
        motor_cfg_pkg::IDX_NEG_LIMIT: state_next.neg_limit = req.wdata & motor_cfg_pkg::IO_MASK;
        motor_cfg_pkg::IDX_POS_LIMIT: state_next.pos_limit = req.wdata & motor_cfg_pkg::IO_MASK;
        motor_cfg_pkg::IDX_SERVO_ON: state_next.servo_on = req.wdata & motor_cfg_pkg::IO_MASK;
        motor_cfg_pkg::IDX_HOME_SELECT: state_next.home_sel = req.wdata & motor_cfg_pkg::IO_MASK;
        default: state_next.rdata = state_reg.rdata;
      endcase
    end
    // Distance only latches from an index search; out-of-range values saturate
    if (homing_done && homing_used_index)
    begin
      if (homing_index_distance > motor_cfg_pkg::INDEX_DISTANCE_MAX)
        state_next.index_distance = motor_cfg_pkg::INDEX_DISTANCE_MAX;
      else
        state_next.index_distance = homing_index_distance;
    end
    // Read data exists only in the cycle after a read strobe
    state_next.rdata = motor_cfg_pkg::RST_ZERO;
    if (req.rd)
    begin
      case (req.addr)
        motor_cfg_pkg::IDX_SAMPLE_COUNT: state_next.rdata = state_reg.sample_count;
        motor_cfg_pkg::IDX_SAMPLE_PERIOD: state_next.rdata = state_reg.sample_period;
        motor_cfg_pkg::IDX_SCOPE_CONTROL: state_next.rdata = state_reg.scope_control;
        motor_cfg_pkg::IDX_BUFFER_CAPACITY: state_next.rdata = motor_cfg_pkg::BUFFER_CAPACITY_VALUE;
        motor_cfg_pkg::IDX_INDEX_DISTANCE: state_next.rdata = {21'h0, state_reg.index_distance};
        motor_cfg_pkg::IDX_HOMING_OPTIONS: state_next.rdata = state_reg.homing;
        motor_cfg_pkg::IDX_OPTION_FLAGS: state_next.rdata = state_reg.options;
        motor_cfg_pkg::IDX_IO_SETUP: state_next.rdata = state_reg.io_setup;
        motor_cfg_pkg::IDX_TABLE_MODE: state_next.rdata = state_reg.table_mode;
        motor_cfg_pkg::IDX_TABLE_LENGTH: state_next.rdata = state_reg.table_length;
        motor_cfg_pkg::IDX_NEG_LIMIT: state_next.rdata = state_reg.neg_limit;
        motor_cfg_pkg::IDX_POS_LIMIT: state_next.rdata = state_reg.pos_limit;
        motor_cfg_pkg::IDX_SERVO_ON: state_next.rdata = state_reg.servo_on;
        motor_cfg_pkg::IDX_HOME_SELECT: state_next.rdata = state_reg.home_sel;
        default: state_next.rdata = motor_cfg_pkg::RST_ZERO;
      endcase
    end
    // Decoded views are registered so every output leaves a flip-flop;
    // they trail the stored register by one cycle
    state_next.scope.sample_count = state_reg.sample_count;
    state_next.scope.sample_period_ms = state_reg.sample_period;
    state_next.scope.scope_control = state_reg.scope_control;
    state_next.hom.index_search = state_reg.homing[motor_cfg_pkg::HB_INDEX];
    state_next.hom.index_only = state_reg.homing[motor_cfg_pkg::HB_IGNORE_SWITCH];
    state_next.hom.reverse_on_limit = state_reg.homing[motor_cfg_pkg::HB_REVERSE];
    state_next.hom.opposite_side = state_reg.homing[motor_cfg_pkg::HB_OPPOSITE];
    state_next.opt.invert_dir = state_reg.options[motor_cfg_pkg::OB_INVERT];
    state_next.opt.no_autostart = state_reg.options[motor_cfg_pkg::OB_NO_AUTOSTART];
    state_next.opt.enc_kind = decode_encoder(state_reg.options[motor_cfg_pkg::OB_ENC_TYPE_LO +: 2]);
    state_next.opt.enc_enable = (decode_encoder(state_reg.options[motor_cfg_pkg::OB_ENC_TYPE_LO +: 2])
                                 != motor_cfg_pkg::ENC_OFF);
    state_next.opt.enc_out_en = {state_reg.options[motor_cfg_pkg::OB_ENC_I_OUT],
                                 state_reg.options[motor_cfg_pkg::OB_ENC_B_OUT],
                                 state_reg.options[motor_cfg_pkg::OB_ENC_A_OUT]};
    state_next.opt.no_limit_error = state_reg.options[motor_cfg_pkg::OB_NO_LIMIT_ERR];
    state_next.opt.resync_after_passive = state_reg.options[motor_cfg_pkg::OB_RESYNC];
    state_next.opt.phys_position = state_reg.options[motor_cfg_pkg::OB_PHYS_POS];
    state_next.opt.copy_enc_to_actual_position = state_reg.options[motor_cfg_pkg::OB_COPY_ENC];
    state_next.opt.multiturn = state_reg.options[motor_cfg_pkg::OB_MULTITURN];
    state_next.opt.retain_external_count = state_reg.options[motor_cfg_pkg::OB_RETAIN_EXT];
    state_next.opt.retain_absolute_count = state_reg.options[motor_cfg_pkg::OB_RETAIN_ABS];
    state_next.opt.external_count_direction = state_reg.options[motor_cfg_pkg::OB_EXT_DIR];
    state_next.io.active_level = state_reg.io_setup[7:0];
    state_next.io.output_en = state_reg.io_setup[15:8];
    state_next.io.table_mode = motor_cfg_pkg::table_mode_type'(state_reg.table_mode[1:0]);
    state_next.io.table_active = (state_reg.table_mode[1:0] != 2'h0);
    // Modulo reads as zero in linear mode so downstream never wraps by accident
    state_next.io.table_modulo = (state_reg.table_mode[1:0] != 2'h0) ? state_reg.table_length
                                 : motor_cfg_pkg::RST_ZERO;
    state_next.io.neg_limit_sel = state_reg.neg_limit[7:0];
    state_next.io.pos_limit_sel = state_reg.pos_limit[7:0];
    state_next.io.servo_on_sel = state_reg.servo_on[7:0];
    state_next.io.home_sel = state_reg.home_sel[7:0];
    if (sys_rst)
    begin
      state_next = '0;
      state_next.sample_period = motor_cfg_pkg::RST_SAMPLE_PERIOD;
      state_next.scope.sample_period_ms = motor_cfg_pkg::RST_SAMPLE_PERIOD;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge ref_clk)
  begin
    state_reg <= state_next;
  end

  assign reg_rdata = state_reg.rdata;
  assign scope_cfg = state_reg.scope;
  assign homing_cfg = state_reg.hom;
  assign option_cfg = state_reg.opt;
  assign io_cfg = state_reg.io;

endmodule : motor_config_register_bank

// *** homing_model.sv ***
`timescale 1ns/1ns
// Stands in for the homing engine: one report pulse per trigger
module homing_model (
  // Clock and control from the bench
  input wire logic ref_clk,
  input wire logic trig,
  input wire logic use_idx,
  input wire logic [10:0] dist_in,
  // Report towards the register bank
  output logic homing_done,
  output logic homing_used_index,
  output logic [10:0] homing_index_distance
);
  initial
  begin
    homing_done = 1'b0;
    homing_used_index = 1'b0;
    homing_index_distance = 11'h000;
  end
  // Distance only holds during the report; it toggles otherwise so a stale capture shows up
  always @(posedge ref_clk)
  begin
    homing_done <= trig;
    homing_used_index <= trig & use_idx;
    homing_index_distance <= trig ? dist_in : ~homing_index_distance;
  end
endmodule : homing_model

// *** motor_cfg_assertions.sv ***
`timescale 1ns/1ns
module motor_cfg_assertions (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Homing report
  input wire logic homing_done,
  input wire logic homing_used_index,
  input wire logic [10:0] homing_index_distance,
  // Configuration outputs
  input wire motor_cfg_pkg::scope_cfg_type scope_cfg,
  input wire motor_cfg_pkg::homing_type homing_cfg,
  input wire motor_cfg_pkg::options_type option_cfg,
  input wire motor_cfg_pkg::io_cfg_type io_cfg
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read answer");
  AST_RSVD_READ: assert property (
    reg_rd && reg_addr inside {8'h77, 8'h79, 8'h7B, 8'h80, 8'h85, 8'h86}
    |=> reg_rdata == 32'h0000_0000)
    else $error("reserved or capacity register read nonzero");
  AST_READ_BACK: assert property (
    reg_wr && reg_addr == 8'h74 ##1 reg_rd && reg_addr == 8'h74
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("sample count read back differs from write");
  AST_PERIOD_OUT: assert property (
    reg_wr && reg_addr == 8'h75
    |-> ##2 scope_cfg.sample_period_ms == $past(reg_wdata, 2))
    else $error("sample period output wrong");
  AST_OPTIONS_OUT: assert property (
    reg_wr && reg_addr == 8'h7C |-> ##2 option_cfg.invert_dir == $past(reg_wdata[0], 2)
    && option_cfg.no_limit_error == $past(reg_wdata[17], 2) && option_cfg.enc_kind != 2'h3)
    else $error("option outputs wrong");
  AST_IO_SETUP_OUT: assert property (
    reg_wr && reg_addr == 8'h7D
    |-> ##2 {io_cfg.output_en, io_cfg.active_level} == $past(reg_wdata[15:0], 2))
    else $error("io setup outputs wrong");
  AST_HOME_OUT: assert property (reg_wr && reg_addr == 8'h84 |-> ##2 io_cfg.home_sel == $past(reg_wdata[7:0], 2))
    else $error("home select output wrong");
  AST_MODULO: assert property (
    io_cfg.table_mode == 2'h0
    |-> io_cfg.table_modulo == 32'h0000_0000 && !io_cfg.table_active)
    else $error("modulo active in linear mode");
  AST_INDEX_CAPTURE: assert property (
    homing_done && homing_used_index ##1 reg_rd && reg_addr == 8'h78
    |=> reg_rdata == (($past(homing_index_distance, 2) > 11'h63F) ? 32'h0000_063F
    : {21'h000000, $past(homing_index_distance, 2)}))
    else $error("index distance capture wrong");
  COV_WRITE_READ: cover property (reg_wr ##1 reg_rd);
  COV_CAPTURE: cover property (homing_done && homing_used_index);
  COV_TABLE: cover property (io_cfg.table_active);
endmodule : motor_cfg_assertions

// *** testbench.sv ***
`timescale 1ns/1ns
module testbench;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic trig = 1'b0;
  logic use_idx = 1'b0;
  logic [10:0] dist_in = 11'h000;
  logic [31:0] reg_rdata;
  logic homing_done;
  logic homing_used_index;
  logic [10:0] homing_index_distance;
  motor_cfg_pkg::scope_cfg_type scope_cfg;
  motor_cfg_pkg::homing_type homing_cfg;
  motor_cfg_pkg::options_type option_cfg;
  motor_cfg_pkg::io_cfg_type io_cfg;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  always #5 ref_clk = ~ref_clk;
  motor_config_register_bank u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .homing_done(homing_done),
    .homing_used_index(homing_used_index), .homing_index_distance(homing_index_distance),
    .scope_cfg(scope_cfg), .homing_cfg(homing_cfg), .option_cfg(option_cfg), .io_cfg(io_cfg));
  homing_model u_homing (.ref_clk(ref_clk), .trig(trig), .use_idx(use_idx), .dist_in(dist_in),
    .homing_done(homing_done), .homing_used_index(homing_used_index),
    .homing_index_distance(homing_index_distance));
  // ****************************************************************
  // Bus cycles and comparison
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One idle edge after the strobe drops, so a following write never re-drives it in the same step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask : wr
  // Write and read back to back: the read strobe rises as the write strobe drops
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    chk(reg_rdata, exp);
  endtask : wr_rd
  // Answer is read at the edge after the read edge, before that edge clears it
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    chk(reg_rdata, exp);
  endtask : rd
  // Config outputs lag the register by one more cycle
  task automatic settle;
    repeat (2) @(posedge ref_clk);
  endtask : settle
  function automatic logic [31:0] rw_mask(input logic [7:0] a);
    case (a)
      8'h74, 8'h75, 8'h76, 8'h7F: rw_mask = 32'hFFFF_FFFF;
      8'h7A: rw_mask = 32'h0000_0017;
      8'h7C: rw_mask = 32'h0003_3FEF;
      8'h7D: rw_mask = 32'h0000_FFFF;
      8'h7E: rw_mask = 32'h0000_0003;
      8'h81, 8'h82, 8'h83, 8'h84: rw_mask = 32'h0000_00FF;
      default: rw_mask = 32'h0000_0000;
    endcase
  endfunction : rw_mask
  task automatic t_regs;
    for (int a = 8'h74; a <= 8'h86; a++)
      rd(8'(a), (a == 8'h75) ? 32'h0000_0001 : 32'h0000_0000);
    for (int a = 8'h74; a <= 8'h86; a++)
    begin
      wr_rd(8'(a), 32'hFFFF_FFFF, rw_mask(8'(a)));
      wr(8'(a), 32'h0000_0000);
    end
    wr(8'h74, 32'hA5A5_0001);
    wr(8'h75, 32'h0000_03E8);
    wr(8'h76, 32'h0000_005A);
    settle;
    chk(scope_cfg.sample_count, 32'hA5A5_0001);
    chk(scope_cfg.sample_period_ms, 32'h0000_03E8);
    chk(scope_cfg.scope_control, 32'h0000_005A);
  endtask : t_regs
  task automatic t_options;
    logic [5:0] f;
    for (int k = 0; k < 4; k++)
    begin
      wr(8'h7C, 32'(k << 2) | (k[0] ? 32'h0002_0281 : 32'h0000_0102));
      settle;
      chk(32'(option_cfg.enc_kind), (k == 3) ? 32'h0 : 32'(k));
      chk(32'(option_cfg.enc_enable), (k == 1 || k == 2) ? 32'h1 : 32'h0);
      chk(32'({option_cfg.invert_dir, option_cfg.no_autostart}), k[0] ? 32'h2 : 32'h1);
      chk(32'(option_cfg.enc_out_en), k[0] ? 32'h5 : 32'h2);
      chk(32'(option_cfg.no_limit_error), 32'(k[0]));
    end
    wr(8'h7C, 32'h0001_3C60);
    settle;
    chk(32'(option_cfg.phys_position), 32'h1);
    f = {option_cfg.resync_after_passive, option_cfg.copy_enc_to_actual_position, option_cfg.multiturn,
      option_cfg.retain_external_count, option_cfg.retain_absolute_count, option_cfg.external_count_direction};
    chk(32'(f), 32'h3F);
    wr(8'h7A, 32'h0000_0011);
    settle;
    chk(32'(homing_cfg), 32'h9);
    wr(8'h7A, 32'h0000_0006);
    settle;
    chk(32'(homing_cfg), 32'h6);
  endtask : t_options
  task automatic t_io;
    wr(8'h7D, 32'h0000_C35A);
    wr(8'h81, 32'h0000_0103);
    wr(8'h82, 32'h0000_0040);
    wr(8'h83, 32'h0000_0010);
    wr(8'h84, 32'h0000_0081);
    settle;
    chk(32'({io_cfg.output_en, io_cfg.active_level}), 32'h0000_C35A);
    chk(32'({io_cfg.neg_limit_sel, io_cfg.pos_limit_sel}), 32'h0000_0340);
    chk(32'({io_cfg.servo_on_sel, io_cfg.home_sel}), 32'h0000_1081);
    wr(8'h7F, 32'h0000_0640);
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h7E, 32'(m) | 32'h0000_0004);
      settle;
      chk(32'({io_cfg.table_active, io_cfg.table_mode}), 32'(m) | ((m != 0) ? 32'h4 : 32'h0));
      chk(io_cfg.table_modulo, (m != 0) ? 32'h0000_0640 : 32'h0);
    end
  endtask : t_io
  task automatic home(input logic u, input logic [10:0] d, input logic [31:0] exp);
    trig <= 1'b1;
    use_idx <= u;
    dist_in <= d;
    @(posedge ref_clk);
    trig <= 1'b0;
    @(posedge ref_clk);
    rd(8'h78, exp);
  endtask : home
  task automatic complete_run;
    $display("Mismatches %0d, checks %0d", err_count, total_checks);
    if (err_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      err_count++;
      complete_run;
    end
  end
  initial
  begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    t_regs;
    t_options;
    t_io;
    home(1'b1, 11'h064, 32'h0000_0064);
    home(1'b1, 11'h63F, 32'h0000_063F);
    home(1'b1, 11'h7D0, 32'h0000_063F);
    home(1'b0, 11'h005, 32'h0000_063F);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    rd(8'h75, 32'h0000_0001);
    rd(8'h7E, 32'h0000_0000);
    complete_run;
  end
endmodule : testbench
bind motor_config_register_bank motor_cfg_assertions u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .homing_done(homing_done), .homing_used_index(homing_used_index), .homing_index_distance(homing_index_distance),
  .scope_cfg(scope_cfg), .homing_cfg(homing_cfg), .option_cfg(option_cfg), .io_cfg(io_cfg));
